// File: speed_status_pkg.sv
// constants for the speed status and torque source block
// assumes a 125 MHz control clock and a classic wishbone register bus
//
// How it works
// - zero-speed flag high while absolute speed is below its threshold
// - zero-speed flag reaches an output terminal only when its selector holds code 133
// - zero-speed threshold in rpm, resets to 10, range 0 to 6000
// - speed-match flag high while absolute speed error is within threshold
// - speed-match flag reaches an output terminal only when its selector holds code 136
// - speed-match threshold in rpm, resets to 10, range 0 to 100
// - approach flag high while absolute speed is strictly above threshold
// - approach flag reaches an output terminal only when its selector holds code 137
// - approach threshold in rpm, resets to 100, range 10 to 6000
// - torque source 0 internal, 1 analog one; reset 0; change only when stopped
// - internal torque signed, 0.1 percent steps, -3000 to 3000, resets to 0
// - analog source: channel one gives torque, channel two gives limit
// - reduced variant supports internal source only; value 1 refused
package speed_status_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned DO_NUM = 4;

  // register word offsets (byte addresses)
  localparam logic [7:0] ADDR_ZERO_THR   = 8'h00;
  localparam logic [7:0] ADDR_MATCH_THR  = 8'h04;
  localparam logic [7:0] ADDR_APPR_THR   = 8'h08;
  localparam logic [7:0] ADDR_TRQ_SRC    = 8'h0c;
  localparam logic [7:0] ADDR_TRQ_INT    = 8'h10;
  localparam logic [7:0] ADDR_DO_SEL     = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20;

  // reset values
  localparam logic [15:0] RST_ZERO_THR  = 16'h000a;
  localparam logic [15:0] RST_MATCH_THR = 16'h000a;
  localparam logic [15:0] RST_APPR_THR  = 16'h0064;
  localparam logic [15:0] RST_TRQ_SRC   = 16'h0000;
  localparam logic [15:0] RST_TRQ_INT   = 16'h0000;

  // legal ranges
  localparam logic [15:0] MAX_ZERO_THR  = 16'h1770;
  localparam logic [15:0] MAX_MATCH_THR = 16'h0064;
  localparam logic [15:0] MIN_APPR_THR  = 16'h000a;
  localparam logic [15:0] MAX_APPR_THR  = 16'h1770;
  localparam logic signed [15:0] MAX_TRQ = 16'sh0bb8;
  localparam logic signed [15:0] MIN_TRQ = -16'sh0bb8;

  // output terminal function codes
  localparam logic [7:0] FUNC_ZERO  = 8'h85;
  localparam logic [7:0] FUNC_MATCH = 8'h88;
  localparam logic [7:0] FUNC_APPR  = 8'h89;

  // status / interrupt bit positions
  localparam int unsigned BIT_ZERO    = 0;
  localparam int unsigned BIT_MATCH   = 1;
  localparam int unsigned BIT_APPR    = 2;
  localparam int unsigned BIT_SRC     = 3;
  localparam int unsigned BIT_REFUSED = 4;
  localparam int unsigned IRQ_W       = 5;

  typedef enum logic { SRC_INTERNAL, SRC_ANALOG } trq_src_t;

endpackage : speed_status_pkg

// File: speed_status_torque_source.sv
// speed comparison flags, output terminal routing and torque source selection
// assumes speed and instruction samples arrive from logic on the same clock,
// each qualified by a one-cycle sample strobe
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
module speed_status_torque_source #(
  parameter bit ANALOG_SUPPORTED = 1'b1
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_sample_valid,
  input  wire logic [15:0] i_speed_raw,
  input  wire logic [15:0] i_speed_filt,
  input  wire logic [15:0] i_speed_instr,
  input  wire logic [15:0] i_analog_channel_one,
  input  wire logic [15:0] i_analog_channel_two,
  output logic      [15:0] o_torque_instr,
  output logic      [15:0] o_torque_limit,
  output logic             o_torque_limit_ext,
  output logic             o_zero_speed_flag,
  output logic             o_speed_match_flag,
  output logic             o_speed_approach_flag,
  output logic [3:0]       o_do,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction : abs16

  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_u

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // registers

  localparam int unsigned IRQ_W_C = speed_status_pkg::IRQ_W;

  logic [15:0] zero_speed_threshold;
  logic [15:0] speed_match_threshold;
  logic [15:0] speed_approach_threshold;
  logic        torque_source_select;
  logic [15:0] internal_torque_value;
  logic [31:0] do_select;
  logic [IRQ_W_C-1:0] irq_status;
  logic [IRQ_W_C-1:0] irq_mask;
  logic        zero_speed_flag;
  logic        speed_match_flag;
  logic        speed_approach_flag;
  logic        src_refused;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire         bus_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire         bus_wr    = bus_req & i_wb_we;
  wire         bus_rd    = bus_req & ~i_wb_we;
  wire         wr_zero   = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_ZERO_THR);
  wire         wr_match  = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_MATCH_THR);
  wire         wr_appr   = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_APPR_THR);
  wire         wr_src    = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_TRQ_SRC);
  wire         wr_trq    = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_TRQ_INT);
  wire         wr_dosel  = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_DO_SEL);
  wire         wr_mask   = bus_wr & (i_wb_adr == speed_status_pkg::ADDR_IRQ_MASK);
  wire         rd_irq    = bus_rd & (i_wb_adr == speed_status_pkg::ADDR_IRQ_STATUS);

  wire  [15:0] src_word  = merge({15'h0000, torque_source_select}, i_wb_dat, i_wb_sel);
  // changing the source is only legal at standstill, and only with analog hardware
  wire         src_ok    = zero_speed_flag & (~src_word[0] | ANALOG_SUPPORTED);
  wire  [15:0] trq_word  = merge(internal_torque_value, i_wb_dat, i_wb_sel);
  wire  [15:0] trq_sat   = ($signed(trq_word) > speed_status_pkg::MAX_TRQ) ?
                           speed_status_pkg::MAX_TRQ :
                           (($signed(trq_word) < speed_status_pkg::MIN_TRQ) ?
                           speed_status_pkg::MIN_TRQ : trq_word);

  logic [31:0] next_rd_data;
  always_comb begin
    case (i_wb_adr)
      speed_status_pkg::ADDR_ZERO_THR:   next_rd_data = {16'h0000, zero_speed_threshold};
      speed_status_pkg::ADDR_MATCH_THR:  next_rd_data = {16'h0000, speed_match_threshold};
      speed_status_pkg::ADDR_APPR_THR:   next_rd_data = {16'h0000, speed_approach_threshold};
      speed_status_pkg::ADDR_TRQ_SRC:    next_rd_data = {31'h00000000, torque_source_select};
      speed_status_pkg::ADDR_TRQ_INT:    next_rd_data = {16'h0000, internal_torque_value};
      speed_status_pkg::ADDR_DO_SEL:     next_rd_data = do_select;
      speed_status_pkg::ADDR_STATUS:     next_rd_data = {27'h0000000, src_refused,
                                                         torque_source_select,
                                                         speed_approach_flag,
                                                         speed_match_flag, zero_speed_flag};
      speed_status_pkg::ADDR_IRQ_STATUS: next_rd_data = {27'h0000000, irq_status};
      speed_status_pkg::ADDR_IRQ_MASK:   next_rd_data = {27'h0000000, irq_mask};
      default:                           next_rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_rd ? next_rd_data : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter registers, threshold and torque writes clamped into legal range, bad source writes refused

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      zero_speed_threshold     <= speed_status_pkg::RST_ZERO_THR;
      speed_match_threshold    <= speed_status_pkg::RST_MATCH_THR;
      speed_approach_threshold <= speed_status_pkg::RST_APPR_THR;
      torque_source_select     <= 1'b0;
      internal_torque_value    <= speed_status_pkg::RST_TRQ_INT;
      do_select                <= 32'h00000000;
      irq_mask                 <= '0;
      src_refused              <= 1'b0;
    end else begin
      if (wr_zero)
        zero_speed_threshold <= clamp_u(merge(zero_speed_threshold, i_wb_dat, i_wb_sel),
                                        16'h0000, speed_status_pkg::MAX_ZERO_THR);
      if (wr_match)
        speed_match_threshold <= clamp_u(merge(speed_match_threshold, i_wb_dat, i_wb_sel),
                                         16'h0000, speed_status_pkg::MAX_MATCH_THR);
      if (wr_appr)
        speed_approach_threshold <= clamp_u(merge(speed_approach_threshold, i_wb_dat,
                                              i_wb_sel), speed_status_pkg::MIN_APPR_THR,
                                            speed_status_pkg::MAX_APPR_THR);
      if (wr_src && src_ok && src_word[15:1] == 15'h0000)
        torque_source_select <= src_word[0];
      if (wr_src)
        src_refused <= ~(src_ok && src_word[15:1] == 15'h0000);
      if (wr_trq)
        internal_torque_value <= trq_sat;
      if (wr_dosel)
        do_select <= {i_wb_sel[3] ? i_wb_dat[31:24] : do_select[31:24],
                      i_wb_sel[2] ? i_wb_dat[23:16] : do_select[23:16],
                      i_wb_sel[1] ? i_wb_dat[15:8]  : do_select[15:8],
                      i_wb_sel[0] ? i_wb_dat[7:0]   : do_select[7:0]};
      if (wr_mask && i_wb_sel[0])
        irq_mask <= i_wb_dat[IRQ_W_C-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparisons, evaluated only on a sample strobe

  wire  [15:0] abs_raw   = abs16(i_speed_raw);
  wire  [15:0] abs_filt  = abs16(i_speed_filt);
  wire  [16:0] diff      = {i_speed_filt[15], i_speed_filt} - {i_speed_instr[15], i_speed_instr};
  wire  [16:0] abs_diff  = diff[16] ? 17'(-diff) : diff;
  wire         next_zero  = abs_raw < zero_speed_threshold;
  wire         next_match = abs_diff <= {1'b0, speed_match_threshold};
  wire         next_appr  = abs_filt > speed_approach_threshold;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      zero_speed_flag     <= 1'b0;
      speed_match_flag    <= 1'b0;
      speed_approach_flag <= 1'b0;
    end else if (i_sample_valid) begin
      zero_speed_flag     <= next_zero;
      speed_match_flag    <= next_match;
      speed_approach_flag <= next_appr;
    end
  end

  assign o_zero_speed_flag     = zero_speed_flag;
  assign o_speed_match_flag    = speed_match_flag;
  assign o_speed_approach_flag = speed_approach_flag;

  ////////////////////////////////////////////////////////////////////////////
  // output terminal routing, one selector byte per terminal

  logic [3:0] next_do;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      case (do_select[8*k +: 8])
        speed_status_pkg::FUNC_ZERO:  next_do[k] = zero_speed_flag;
        speed_status_pkg::FUNC_MATCH: next_do[k] = speed_match_flag;
        speed_status_pkg::FUNC_APPR:  next_do[k] = speed_approach_flag;
        default:                      next_do[k] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst)
      o_do <= 4'h0;
    else
      o_do <= next_do;
  end

  ////////////////////////////////////////////////////////////////////////////
  // torque instruction source

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_torque_instr     <= 16'h0000;
      o_torque_limit     <= 16'h0000;
      o_torque_limit_ext <= 1'b0;
    end else if (torque_source_select) begin
      o_torque_instr     <= i_analog_channel_one;
      o_torque_limit     <= i_analog_channel_two;
      o_torque_limit_ext <= 1'b1;
    end else begin
      o_torque_instr     <= internal_torque_value;
      o_torque_limit     <= 16'h0000;
      o_torque_limit_ext <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: edges of the flags, source select and refused status; read clears, set wins

  logic [IRQ_W_C-1:0] prev_flags;
  wire  [IRQ_W_C-1:0] cur_flags = {src_refused, torque_source_select, speed_approach_flag,
                                   speed_match_flag, zero_speed_flag};
  wire  [IRQ_W_C-1:0] irq_event = cur_flags ^ prev_flags;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      prev_flags <= '0;
      irq_status <= '0;
    end else begin
      prev_flags <= cur_flags;
      irq_status <= (rd_irq ? '0 : irq_status) | irq_event;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

endmodule : speed_status_torque_source

// File: speed_status_torque_source_chk.sv
// concurrent checks on the speed status block's ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
module speed_status_torque_source_chk #(
  parameter bit ANALOG_SUPPORTED = 1'b1
) (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        o_wb_ack,
  input wire logic        i_sample_valid,
  input wire logic [15:0] i_speed_raw,
  input wire logic [15:0] i_speed_filt,
  input wire logic [15:0] i_speed_instr,
  input wire logic [15:0] i_analog_channel_one,
  input wire logic [15:0] o_torque_instr,
  input wire logic [15:0] o_torque_limit,
  input wire logic        o_torque_limit_ext,
  input wire logic        o_zero_speed_flag,
  input wire logic        o_speed_match_flag,
  input wire logic        o_speed_approach_flag,
  input wire logic [3:0]  o_do
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire signed [16:0] diff = $signed(i_speed_filt) - $signed(i_speed_instr);
  wire        raw_fast = $signed(i_speed_raw) >= 6000 || $signed(i_speed_raw) <= -6000;
  wire        filt_fast = $signed(i_speed_filt) > 6000 || $signed(i_speed_filt) < -6000;
  wire        filt_slow = $signed(i_speed_filt) <= 10 && $signed(i_speed_filt) >= -10;
  wire        diff_big = diff > 100 || diff < -100;
  wire [2:0]  flags = {o_speed_approach_flag, o_speed_match_flag, o_zero_speed_flag};
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acked");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_hold; !i_sample_valid |=> $stable(flags); endproperty
  a_hold: assert property (p_hold) else $error("flag moved without sample");
  property p_zero; i_sample_valid && raw_fast |=> !o_zero_speed_flag; endproperty
  a_zero: assert property (p_zero) else $error("zero flag at high speed");
  property p_appr_hi; i_sample_valid && filt_fast |=> o_speed_approach_flag; endproperty
  a_appr_hi: assert property (p_appr_hi) else $error("approach flag low");
  property p_appr_lo; i_sample_valid && filt_slow |=> !o_speed_approach_flag; endproperty
  a_appr_lo: assert property (p_appr_lo) else $error("approach flag high");
  property p_match; i_sample_valid && diff_big |=> !o_speed_match_flag; endproperty
  a_match: assert property (p_match) else $error("match flag on big error");
  property p_do; |o_do |-> |$past(flags); endproperty
  a_do: assert property (p_do) else $error("terminal high without flag");
  property p_ext; o_torque_limit_ext |-> o_torque_instr == $past(i_analog_channel_one);
  endproperty
  a_ext: assert property (p_ext) else $error("torque not from channel one");
  property p_lim; !o_torque_limit_ext |-> o_torque_limit == 16'h0000; endproperty
  a_lim: assert property (p_lim) else $error("limit without analog source");
  property p_red; !ANALOG_SUPPORTED |-> !o_torque_limit_ext; endproperty
  a_red: assert property (p_red) else $error("analog source in reduced variant");
  c_zero: cover property (i_sample_valid ##1 o_zero_speed_flag);
  c_appr: cover property (i_sample_valid ##1 o_speed_approach_flag);
  c_ext: cover property (o_torque_limit_ext);
endmodule : speed_status_torque_source_chk

bind speed_status_torque_source speed_status_torque_source_chk #(
  .ANALOG_SUPPORTED(ANALOG_SUPPORTED)) i_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_sample_valid(i_sample_valid), .i_speed_raw(i_speed_raw), .i_speed_filt(i_speed_filt),
  .i_speed_instr(i_speed_instr), .i_analog_channel_one(i_analog_channel_one),
  .o_torque_instr(o_torque_instr), .o_torque_limit(o_torque_limit),
  .o_torque_limit_ext(o_torque_limit_ext), .o_zero_speed_flag(o_zero_speed_flag),
  .o_speed_match_flag(o_speed_match_flag), .o_speed_approach_flag(o_speed_approach_flag),
  .o_do(o_do));

// File: host_do_reader.sv
// host side model: samples the drive's terminal outputs once a clock
// assumes terminals are registered in the drive's clock domain
`timescale 1ns/1ps
module host_do_reader (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_do,
  output logic      [3:0] o_seen
);
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) o_seen <= 4'h0;
    else o_seen <= i_do;
  end
endmodule : host_do_reader

// File: speed_status_torque_source_test.sv
// self-checking bench for the speed status and torque source block
// assumes the wishbone slave acks one cycle after it takes a request
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module speed_status_torque_source_test;
  logic clk, rst, cyc, stb, we, sv;
  logic [7:0] adr;
  logic [31:0] wdat, q;
  logic [15:0] raw, filt, instr;
  wire [31:0] rdat;
  wire [15:0] trq, lim;
  wire ack, ext, zf, mf, af, irq;
  wire [3:0] do_o, seen;
  int num_errors = 0;
  int n_compared = 0;
  speed_status_torque_source i_speed_status_torque_source (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sample_valid(sv),
    .i_speed_raw(raw), .i_speed_filt(filt), .i_speed_instr(instr),
    .i_analog_channel_one(16'h0123), .i_analog_channel_two(16'h0456),
    .o_torque_instr(trq), .o_torque_limit(lim), .o_torque_limit_ext(ext),
    .o_zero_speed_flag(zf), .o_speed_match_flag(mf), .o_speed_approach_flag(af),
    .o_do(do_o), .o_irq(irq));
  host_do_reader i_host_do_reader (.i_ref_clk(clk), .i_sys_rst(rst), .i_do(do_o),
    .o_seen(seen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic smp(input logic [15:0] r, input logic [15:0] f, input logic [15:0] s);
    sv <= 1'b1;
    raw <= r;
    filt <= f;
    instr <= s;
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : smp
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [15:0] e [5] = '{16'h000a, 16'h000a, 16'h0064, 16'h0000, 16'h0000};
    logic [15:0] c [3] = '{16'h1b58, 16'h00c8, 16'h0005};
    logic [15:0] m [3] = '{16'h1770, 16'h0064, 16'h000a};
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, a[i], 32'h0);
      `CHK("reset value", {16'h0, e[i]}, q)
    end
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, a[i], {16'h0, c[i]});
      wb(1'b0, a[i], 32'h0);
      `CHK("clamped value", {16'h0, m[i]}, q)
      wb(1'b1, a[i], {16'h0, e[i]});
    end
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    $display("test t_regs done");
  endtask : t_regs
  task automatic t_flags;
    logic [15:0] r [4] = '{16'h0009, 16'hfff6, 16'hfff7, 16'h000a};
    logic [15:0] f [4] = '{16'h0064, 16'h0065, 16'hff9b, 16'hff9c};
    logic [15:0] s [4] = '{16'h005a, 16'h0070, 16'hffa5, 16'h0000};
    logic [2:0] e [4] = '{3'b011, 3'b100, 3'b111, 3'b000};
    wb(1'b1, 8'h14, 32'h00898885);
    for (int i = 0; i < 4; i++) begin
      smp(r[i], f[i], s[i]);
      `CHK("flags", e[i], {af, mf, zf})
      `CHK("terminals", {1'b0, e[i]}, seen)
    end
    wb(1'b1, 8'h08, 32'h000000c8);
    smp(16'h0000, 16'h0096, 16'h0096);
    `CHK("new threshold", 3'b011, {af, mf, zf})
    wb(1'b1, 8'h08, 32'h00000064);
    $display("test t_flags done");
  endtask : t_flags
  task automatic t_src;
    wb(1'b1, 8'h10, 32'h00000fa0);
    `CHK("internal torque max", 16'h0bb8, trq)
    wb(1'b1, 8'h10, 32'h0000f254);
    `CHK("internal torque min", 16'hf448, trq)
    smp(16'h03e8, 16'h0000, 16'h0000);
    wb(1'b1, 8'h0c, 32'h00000001);
    wb(1'b0, 8'h18, 32'h0);
    `CHK("refused source", 2'b10, q[4:3])
    smp(16'h0000, 16'h0000, 16'h0000);
    wb(1'b1, 8'h0c, 32'h00000001);
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("analog source", {ext, trq, lim, q}, {1'b1, 32'h01230456, 32'h1})
    wb(1'b1, 8'h0c, 32'h00000000);
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("internal source", {ext, trq, lim}, {1'b0, 32'hf4480000})
    $display("test t_src done");
  endtask : t_src
  task automatic t_irq;
    logic i0;
    wb(1'b0, 8'h1c, 32'h0);
    smp(16'h03e8, 16'h0000, 16'h0000);
    wb(1'b1, 8'h20, 32'h00000000);
    i0 = irq;
    wb(1'b1, 8'h20, 32'h0000001f);
    `CHK("irq follows mask", 1'b1, i0 ^ irq)
    wb(1'b0, 8'h1c, 32'h0);
    `CHK("zero event", 1'b1, q[0])
    wb(1'b0, 8'h1c, 32'h0);
    `CHK("read clears", {1'b0, 1'b0}, {q[0], irq})
    $display("test t_irq done");
  endtask : t_irq
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {rst, cyc, stb, we, sv, adr, wdat, raw, filt, instr} = {1'b1, 92'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_flags();
    t_src();
    t_irq();
    print_verdict();
  end
endmodule : speed_status_torque_source_test
